// ==== design/epp_defines.svh ====
// Offsets, field positions, reset values and timing for the preload engine
`ifndef EPP_DEFINES_SVH
`define EPP_DEFINES_SVH

// EEPROM word addresses, in load order
`define EPP_WORD_P0 8'h10
`define EPP_WORD_P1 8'h12
`define EPP_WORD_P2 8'h14
`define EPP_WORD_AMP 8'h18
`define EPP_WORD_DEEMPH 8'h1A
`define EPP_WORD_PHY2 8'h1C
`define EPP_WORD_MISC0 8'h20
`define EPP_WORD_MISC1 8'h22
`define EPP_LAST_IDX 3'h7

// Fields within an EEPROM word
`define EPP_W_FTS 7:0
`define EPP_W_PPM 9:8
`define EPP_W_SCR 11:10
`define EPP_W_L0S 12
`define EPP_W_AMP_LOW 4:0
`define EPP_W_AMP_HIGH 9:5
`define EPP_W_AMP_HALF 14:10
`define EPP_W_DEEMPH 4:0
`define EPP_W_PHY_LAT 3:0
`define EPP_W_RX_DET 6:4
`define EPP_W_SLOT_IMPL 0
`define EPP_W_SLOT_CLK 1
`define EPP_W_DSI 2
`define EPP_W_PORT_NUM 5:4
`define EPP_W_PM_SCALE 7:6
`define EPP_W_TC_MAP 15:9

// Fields within the config dwords
`define EPP_B8_FTS 7:0
`define EPP_A8_PPM 14:13
`define EPP_B8_SCR_P0 11:10
`define EPP_B8_L0S_P0 12
`define EPP_B8_SCR_PN 9:8
`define EPP_B8_L0S_PN 10
`define EPP_B4_AMP_LOW 20:16
`define EPP_B4_AMP_HIGH 25:21
`define EPP_B4_AMP_HALF 30:26
`define EPP_B8_DEEMPH 20:16
`define EPP_BC_PHY_LAT 3:0
`define EPP_BC_RX_DET 6:4
`define EPP_F0_SLOT_CLK 28
`define EPP_80_DSI 21
`define EPP_EC_PORT_NUM 25:24
`define EPP_84_PM_SCALE 14:13
`define EPP_154_TC_MAP 7:1
`define EPP_E0_SLOT_IMPL 24

// Register images held until a load replaces them word by word
`define EPP_A8_RST 32'h0000_0000
`define EPP_B4_RST 32'h0000_0000
`define EPP_B8_RST 32'h0000_0000
`define EPP_BC_RST 32'h0000_0000
`define EPP_80_RST 32'h0000_0000
`define EPP_84_RST 32'h0000_0000
`define EPP_EC_RST 32'h0000_0000
`define EPP_F0_RST 32'h0000_0000
`define EPP_E0_RST 32'h0000_0000
`define EPP_154_RST 32'h0000_0000

// Timing: clock period, EEPROM answer timeout, strap settle time
`define EPP_CLK_PERIOD_NS 10
`define EPP_ACK_TIMEOUT_NS 10000
`define EPP_ACK_TIMEOUT_CYC (`EPP_ACK_TIMEOUT_NS / `EPP_CLK_PERIOD_NS)
`define EPP_SETTLE_CYC 3'h4

`endif

// ==== design/epp_pkg.sv ====
// Types shared by the preload engine and its pin synchroniser
package epp_pkg;

  // One port's preloadable config dwords
  typedef struct packed {
    logic [31:0] a8;
    logic [31:0] b4;
    logic [31:0] b8;
    logic [31:0] bc;
    logic [31:0] r80;
    logic [31:0] r84;
    logic [31:0] ec;
    logic [31:0] f0;
    logic [31:0] e0;
    logic [31:0] r154;
  } epp_image_type;

  typedef epp_image_type [2:0] epp_ports_type;

  typedef enum logic [1:0] {
    EPP_SETTLE,
    EPP_REQ,
    EPP_GAP,
    EPP_DONE
  } epp_phase_type;

  typedef struct packed {
    epp_phase_type phase;
    logic [2:0] settle;
    logic [2:0] idx;
    logic [7:0] addr;
    logic [9:0] tmr;
    logic fail;
    epp_ports_type img;
  } epp_state_type;

  typedef struct packed {
    logic [2:0] ff;
    logic level;
  } epp_sync_type;

endpackage

// ==== design/epp_sync3.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module epp_sync3
  import epp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Pin and filtered level
  input wire logic pin_i,
  output logic level_o
);

  epp_sync_type st;
  epp_sync_type next_st;

  // Stage 0 feeds only stage 1; level moves when stages 1 and 2 agree
  always_comb begin
    next_st = st;
    next_st.ff = {st.ff[1:0], pin_i};
    if (st.ff[1] == st.ff[2]) begin
      next_st.level = st.ff[2];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.level;

endmodule
`default_nettype wire

// ==== design/epp_preload.sv ====
// Preload engine: copies EEPROM words into the ports' config images
`timescale 1ns/10ps
`default_nettype none
`include "epp_defines.svh"
module epp_preload
  import epp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // EEPROM presence strap (pin)
  input wire logic ee_present_i,
  // EEPROM word read port
  output logic ee_rd_req_o,
  output logic [7:0] ee_rd_addr_o,
  input wire logic ee_rd_ack_i,
  input wire logic [15:0] ee_rd_data_i,
  // Config images per port
  output epp_image_type port0_cfg_o,
  output epp_image_type port1_cfg_o,
  output epp_image_type port2_cfg_o,
  // Status and gating
  output logic load_done_o,
  output logic load_fail_o,
  output logic link_train_en_o,
  output logic cfg_access_en_o
);

  localparam logic [9:0] TIMEOUT_LAST = 10'(`EPP_ACK_TIMEOUT_CYC - 1);

  epp_state_type st;
  epp_state_type next_st;
  logic present;
  logic take;

  // Presence strap is asynchronous to the core clock
  epp_sync3 u_present_sync (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .pin_i(ee_present_i),
    .level_o(present)
  );

  // EEPROM word address for each load step
  function automatic logic [7:0] word_addr(input logic [2:0] idx);
    logic [7:0] a;
    case (idx)
      3'h0: a = `EPP_WORD_P0;
      3'h1: a = `EPP_WORD_P1;
      3'h2: a = `EPP_WORD_P2;
      3'h3: a = `EPP_WORD_AMP;
      3'h4: a = `EPP_WORD_DEEMPH;
      3'h5: a = `EPP_WORD_PHY2;
      3'h6: a = `EPP_WORD_MISC0;
      default: a = `EPP_WORD_MISC1;
    endcase
    return a;
  endfunction

  // Default images, restored if a load is abandoned
  function automatic epp_ports_type default_ports();
    epp_image_type i;
    i.a8 = `EPP_A8_RST;
    i.b4 = `EPP_B4_RST;
    i.b8 = `EPP_B8_RST;
    i.bc = `EPP_BC_RST;
    i.r80 = `EPP_80_RST;
    i.r84 = `EPP_84_RST;
    i.ec = `EPP_EC_RST;
    i.f0 = `EPP_F0_RST;
    i.e0 = `EPP_E0_RST;
    i.r154 = `EPP_154_RST;
    return {i, i, i};
  endfunction

  // Scatter one EEPROM word into its target fields
  function automatic epp_ports_type apply_word(
    input epp_ports_type img,
    input logic [2:0] idx,
    input logic [15:0] d
  );
    epp_ports_type p;
    p = img;
    case (idx)
      3'h0: begin
        p[0].b8[`EPP_B8_FTS] = d[`EPP_W_FTS];
        p[0].a8[`EPP_A8_PPM] = d[`EPP_W_PPM];
        p[0].b8[`EPP_B8_SCR_P0] = d[`EPP_W_SCR];
        p[0].b8[`EPP_B8_L0S_P0] = d[`EPP_W_L0S];
      end
      3'h1, 3'h2: begin
        // Ports 1 and 2 share one layout
        p[idx[1:0]].b8[`EPP_B8_FTS] = d[`EPP_W_FTS];
        p[idx[1:0]].a8[`EPP_A8_PPM] = d[`EPP_W_PPM];
        p[idx[1:0]].b8[`EPP_B8_SCR_PN] = d[`EPP_W_SCR];
        p[idx[1:0]].b8[`EPP_B8_L0S_PN] = d[`EPP_W_L0S];
      end
      3'h3: begin
        for (int n = 0; n < 3; n++) begin
          p[n].b4[`EPP_B4_AMP_LOW] = d[`EPP_W_AMP_LOW];
          p[n].b4[`EPP_B4_AMP_HIGH] = d[`EPP_W_AMP_HIGH];
          p[n].b4[`EPP_B4_AMP_HALF] = d[`EPP_W_AMP_HALF];
        end
      end
      3'h4: begin
        // Reserved word bits are dropped
        for (int n = 0; n < 3; n++) begin
          p[n].b8[`EPP_B8_DEEMPH] = d[`EPP_W_DEEMPH];
        end
      end
      3'h5: begin
        for (int n = 0; n < 3; n++) begin
          p[n].bc[`EPP_BC_PHY_LAT] = d[`EPP_W_PHY_LAT];
          p[n].bc[`EPP_BC_RX_DET] = d[`EPP_W_RX_DET];
        end
      end
      3'h6: begin
        p[0].f0[`EPP_F0_SLOT_CLK] = d[`EPP_W_SLOT_CLK];
        p[0].r80[`EPP_80_DSI] = d[`EPP_W_DSI];
        p[0].ec[`EPP_EC_PORT_NUM] = d[`EPP_W_PORT_NUM];
        p[0].r84[`EPP_84_PM_SCALE] = d[`EPP_W_PM_SCALE];
        p[0].r154[`EPP_154_TC_MAP] = d[`EPP_W_TC_MAP];
      end
      default: begin
        p[1].e0[`EPP_E0_SLOT_IMPL] = d[`EPP_W_SLOT_IMPL];
        p[1].f0[`EPP_F0_SLOT_CLK] = d[`EPP_W_SLOT_CLK];
        p[1].r80[`EPP_80_DSI] = d[`EPP_W_DSI];
        p[1].ec[`EPP_EC_PORT_NUM] = d[`EPP_W_PORT_NUM];
        p[1].r84[`EPP_84_PM_SCALE] = d[`EPP_W_PM_SCALE];
      end
    endcase
    return p;
  endfunction

  assign take = (st.phase == EPP_REQ) && ee_rd_ack_i;

  // Load sequencer; the gap state drops the request between words
  always_comb begin
    next_st = st;
    case (st.phase)
      EPP_SETTLE: begin
        // Wait for the strap synchroniser to fill before trusting it
        if (st.settle == `EPP_SETTLE_CYC) begin
          if (present) begin
            next_st.phase = EPP_REQ;
            next_st.addr = word_addr(3'h0);
          end else begin
            next_st.phase = EPP_DONE; // No EEPROM: defaults stand
          end
        end else begin
          next_st.settle = st.settle + 3'h1;
        end
      end
      EPP_REQ: begin
        if (ee_rd_ack_i) begin
          next_st.img = apply_word(st.img, st.idx, ee_rd_data_i);
          next_st.tmr = '0;
          if (st.idx == `EPP_LAST_IDX) begin
            next_st.phase = EPP_DONE;
          end else begin
            next_st.idx = st.idx + 3'h1;
            next_st.addr = word_addr(st.idx + 3'h1);
            next_st.phase = EPP_GAP;
          end
        end else if (st.tmr == TIMEOUT_LAST) begin
          // A dead EEPROM must not leave half-loaded images
          next_st.img = default_ports();
          next_st.fail = 1'b1;
          next_st.phase = EPP_DONE;
        end else begin
          next_st.tmr = st.tmr + 10'h001;
        end
      end
      EPP_GAP: begin
        next_st.phase = EPP_REQ;
      end
      default: begin
        next_st.phase = EPP_DONE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st.phase <= EPP_SETTLE;
      st.settle <= 3'h0;
      st.idx <= 3'h0;
      st.addr <= 8'h00;
      st.tmr <= 10'h000;
      st.fail <= 1'b0;
      st.img <= default_ports();
    end else begin
      st <= next_st;
    end
  end

  // Outputs; ports stay quiet until the sequencer reaches done (all words in, load abandoned, or no EEPROM)
  assign ee_rd_req_o = (st.phase == EPP_REQ);
  assign ee_rd_addr_o = st.addr;
  assign port0_cfg_o = st.img[0];
  assign port1_cfg_o = st.img[1];
  assign port2_cfg_o = st.img[2];
  assign load_done_o = (st.phase == EPP_DONE);
  assign load_fail_o = st.fail;
  assign link_train_en_o = (st.phase == EPP_DONE);
  assign cfg_access_en_o = (st.phase == EPP_DONE);

  // Checks on the load sequence
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_take(int i);
    take && st.idx == 3'(i);
  endsequence

  property p_gate_closed;
    !load_done_o |-> !link_train_en_o && !cfg_access_en_o && !load_fail_o;
  endproperty
  a_gate_closed: assert property (p_gate_closed)
    else $error("port enabled before preload finished");

  property p_done_sticks;
    load_done_o |=> load_done_o && !ee_rd_req_o && $stable(port0_cfg_o)
      && $stable(port1_cfg_o) && $stable(port2_cfg_o);
  endproperty
  a_done_sticks: assert property (p_done_sticks)
    else $error("preload restarted or images changed after done");

  property p_req_hold;
    ee_rd_req_o && !ee_rd_ack_i && !$rose(load_fail_o)
      |=> (ee_rd_req_o || load_fail_o) && $stable(ee_rd_addr_o);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request dropped or address moved before answer");

  property p_p0_word;
    s_take(0) |=> port0_cfg_o.b8[7:0] == $past(ee_rd_data_i[7:0])
      && port0_cfg_o.b8[12:10] == $past(ee_rd_data_i[12:10]);
  endproperty
  a_p0_word: assert property (p_p0_word)
    else $error("port 0 FTS, scrambler or L0s not loaded");

  property p_p1_word;
    s_take(1) |=> port1_cfg_o.b8[10:8] == $past(ee_rd_data_i[12:10])
      && port1_cfg_o.b8[7:0] == $past(ee_rd_data_i[7:0])
      && port1_cfg_o.a8[14:13] == $past(ee_rd_data_i[9:8]);
  endproperty
  a_p1_word: assert property (p_p1_word)
    else $error("port 1 word misplaced");

  property p_p2_word;
    s_take(2) |=> port2_cfg_o.b8[10:8] == $past(ee_rd_data_i[12:10])
      && port2_cfg_o.b8[7:0] == $past(ee_rd_data_i[7:0])
      && port2_cfg_o.a8[14:13] == $past(ee_rd_data_i[9:8]);
  endproperty
  a_p2_word: assert property (p_p2_word)
    else $error("port 2 word misplaced");

  property p_amp;
    s_take(3) |=> port2_cfg_o.b4[30:16] == $past(ee_rd_data_i[14:0])
      && port0_cfg_o.b4[30:16] == port1_cfg_o.b4[30:16];
  endproperty
  a_amp: assert property (p_amp)
    else $error("drive amplitude levels misplaced");

  property p_deemph;
    s_take(4) |=> port1_cfg_o.b8[20:16] == $past(ee_rd_data_i[4:0])
      && port0_cfg_o.b8[20:16] == port2_cfg_o.b8[20:16];
  endproperty
  a_deemph: assert property (p_deemph)
    else $error("de-emphasis level misplaced");

  property p_phy2;
    s_take(5) |=> port0_cfg_o.bc[6:0] == $past(ee_rd_data_i[6:0])
      && port2_cfg_o.bc[6:0] == port1_cfg_o.bc[6:0];
  endproperty
  a_phy2: assert property (p_phy2)
    else $error("PHY latency or detect threshold misplaced");

  property p_misc0;
    s_take(6) |=> port0_cfg_o.f0[28] == $past(ee_rd_data_i[1])
      && port0_cfg_o.r80[21] == $past(ee_rd_data_i[2])
      && port0_cfg_o.ec[25:24] == $past(ee_rd_data_i[5:4])
      && port0_cfg_o.r84[14:13] == $past(ee_rd_data_i[7:6])
      && port0_cfg_o.r154[7:1] == $past(ee_rd_data_i[15:9]);
  endproperty
  a_misc0: assert property (p_misc0)
    else $error("port 0 misc word misplaced");

  property p_misc1;
    s_take(7) |=> port1_cfg_o.e0[24] == $past(ee_rd_data_i[0])
      && port1_cfg_o.f0[28] == $past(ee_rd_data_i[1])
      && port1_cfg_o.r80[21] == $past(ee_rd_data_i[2])
      && port1_cfg_o.ec[25:24] == $past(ee_rd_data_i[5:4])
      && port1_cfg_o.r84[14:13] == $past(ee_rd_data_i[7:6])
      && load_done_o;
  endproperty
  a_misc1: assert property (p_misc1)
    else $error("port 1 misc word misplaced");

  property p_last_word_order;
    s_take(6) |=> !ee_rd_req_o ##1 ee_rd_req_o && ee_rd_addr_o == 8'h22;
  endproperty
  a_last_word_order: assert property (p_last_word_order)
    else $error("word order broken before last word");

endmodule
`default_nettype wire

// ==== verification/epp_eeprom_model.sv ====
// Behavioural EEPROM word server facing the preload engine
`timescale 1ns/10ps
`default_nettype none
module epp_eeprom_model (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Bench controls: answer delay, answer budget, stored words
  input wire logic [9:0] lat_i,
  input wire logic [3:0] ack_limit_i,
  input wire logic [9:0][15:0] words_i,
  // Word read port
  input wire logic rd_req_i,
  input wire logic [7:0] rd_addr_i,
  output logic rd_ack_o,
  output logic [15:0] rd_data_o
);
  logic [9:0] wait_cnt;
  logic [3:0] acks;
  logic [4:0] slot;
  // Words 10h..22h sit two apart
  assign slot = rd_addr_i[5:1] - 5'h08;
  // Data toggles outside the answer cycle so a stale word never passes
  always_ff @(posedge core_clk_i) begin
    rd_ack_o <= 1'b0;
    rd_data_o <= ~rd_data_o;
    if (srst_i) begin
      wait_cnt <= 10'h000;
      acks <= 4'h0;
      rd_data_o <= 16'h5A5A;
    end else if (rd_req_i && !rd_ack_o && acks != ack_limit_i) begin
      if (wait_cnt == lat_i) begin
        rd_ack_o <= 1'b1;
        rd_data_o <= words_i[slot];
        wait_cnt <= 10'h000;
        acks <= acks + 4'h1;
      end else begin
        wait_cnt <= wait_cnt + 10'h001;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/epp_preload_tb_top.sv ====
// Self-checking bench for the preload engine
`timescale 1ns/10ps
`default_nettype none
module epp_preload_tb_top import epp_pkg::*;;
  logic core_clk_i, srst_i, ee_present_i, ee_rd_req_o, ee_rd_ack_i;
  logic [7:0] ee_rd_addr_o;
  logic [15:0] ee_rd_data_i;
  epp_image_type port0_cfg_o, port1_cfg_o, port2_cfg_o;
  logic load_done_o, load_fail_o, link_train_en_o, cfg_access_en_o;
  logic [9:0] lat;
  logic [3:0] lim;
  logic [9:0][15:0] words;
  int errors, tests_run, cyc, last_ack, early, done_cyc;
  logic [7:0] seen[$];
  localparam logic [7:0] word_order [8] = '{8'h10, 8'h12, 8'h14, 8'h18,
    8'h1A, 8'h1C, 8'h20, 8'h22};
  // Reserved bits set on purpose in 1Ah and 1Ch
  localparam logic [9:0][15:0] w_a = {16'h00B5, 16'hFEF6, 16'h0000,
    16'h7F5A, 16'h7FF3, 16'h5A5A, 16'h0000, 16'h1B7E, 16'h0A3C, 16'h15A5};

  epp_preload u_dut (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .ee_present_i(ee_present_i), .ee_rd_req_o(ee_rd_req_o),
    .ee_rd_addr_o(ee_rd_addr_o), .ee_rd_ack_i(ee_rd_ack_i),
    .ee_rd_data_i(ee_rd_data_i), .port0_cfg_o(port0_cfg_o),
    .port1_cfg_o(port1_cfg_o), .port2_cfg_o(port2_cfg_o),
    .load_done_o(load_done_o), .load_fail_o(load_fail_o),
    .link_train_en_o(link_train_en_o), .cfg_access_en_o(cfg_access_en_o));
  epp_eeprom_model u_eeprom (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .lat_i(lat), .ack_limit_i(lim), .words_i(words),
    .rd_req_i(ee_rd_req_o), .rd_addr_i(ee_rd_addr_o),
    .rd_ack_o(ee_rd_ack_i), .rd_data_o(ee_rd_data_i));

  // 100 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // Log every taken word; flag any enable seen in a cycle where a word is taken
  always @(posedge core_clk_i) begin
    cyc++;
    if (ee_rd_req_o === 1'b1 && ee_rd_ack_i === 1'b1) begin
      seen.push_back(ee_rd_addr_o);
      last_ack = cyc;
      if (link_train_en_o !== 1'b0 || cfg_access_en_o !== 1'b0) early++;
    end
  end

  task automatic chk(input logic [319:0] got, input logic [319:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Expected image built from the field map, defaults all zero
  function automatic epp_image_type exp_img(input int p,
                                            input logic [9:0][15:0] w);
    epp_image_type e;
    logic [15:0] d;
    e = '0;
    d = w[p];
    e.b8[7:0] = d[7:0];
    e.a8[14:13] = d[9:8];
    if (p == 0) begin
      e.b8[11:10] = d[11:10];
      e.b8[12] = d[12];
    end else begin
      e.b8[9:8] = d[11:10];
      e.b8[10] = d[12];
    end
    e.b4[20:16] = w[4][4:0];
    e.b4[25:21] = w[4][9:5];
    e.b4[30:26] = w[4][14:10];
    e.b8[20:16] = w[5][4:0];
    e.bc[3:0] = w[6][3:0];
    e.bc[6:4] = w[6][6:4];
    if (p < 2) begin
      d = w[8 + p];
      e.f0[28] = d[1];
      e.r80[21] = d[2];
      e.ec[25:24] = d[5:4];
      e.r84[14:13] = d[7:6];
    end
    if (p == 0) e.r154[7:1] = w[8][15:9];
    if (p == 1) e.e0[24] = w[9][0];
    return e;
  endfunction

  task automatic check_ports(input logic [9:0][15:0] w);
    chk(port0_cfg_o, exp_img(0, w),
        "port 0 image");
    chk(port1_cfg_o, exp_img(1, w), "port 1 image");
    chk(port2_cfg_o, exp_img(2, w), "port 2 image");
  endtask

  // Reset for 5 cycles, then wait for the load under a bound
  task automatic run_case(input logic pres, input logic [9:0] l,
                          input logic [3:0] n, input logic [9:0][15:0] w);
    int k;
    @(posedge core_clk_i);
    srst_i <= 1'b1;
    ee_present_i <= pres;
    lat <= l;
    lim <= n;
    words <= w;
    repeat (5) @(posedge core_clk_i);
    seen.delete();
    early = 0;
    srst_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    chk(load_done_o, 1'b0, "done right after reset");
    k = 0;
    while (load_done_o !== 1'b1 && k < 20000) begin
      @(posedge core_clk_i);
      #1;
      k++;
    end
    done_cyc = cyc;
    if (k == 20000) begin
      errors++;
      $display("wrong value at %0t: load never finished", $time);
      report_and_stop();
    end
    @(posedge core_clk_i);
    #1;
  endtask

  initial begin
    errors = 0;
    tests_run = 0;
    srst_i = 1'b1;
    ee_present_i = 1'b0;
    lat = '0;
    lim = '0;
    words = '0;
    // Prompt answers: order, images and gating
    run_case(1'b1, 10'h000, 4'hF, w_a);
    chk(seen.size(), 8, "word count");
    for (int i = 0; i < 8; i++) begin
      chk(seen[i], word_order[i], "read order");
    end
    check_ports(w_a);
    chk({load_fail_o, link_train_en_o, cfg_access_en_o}, 3'b011,
        "status");
    chk(early, 0, "enable before last word");
    $display("test fast_load done");
    // Slow answers just inside the limit, inverted words and ppm codes
    run_case(1'b1, 10'h3DE, 4'hF, ~w_a);
    check_ports(~w_a);
    chk(load_fail_o, 1'b0, "slow load failed");
    chk(early, 0, "enable before last word");
    $display("test slow_load done");
    // EEPROM goes silent after three words: defaults must return
    run_case(1'b1, 10'h002, 4'h3, w_a);
    chk(seen.size(), 3, "words before silence");
    chk(load_fail_o, 1'b1, "abandon flag");
    chk({port0_cfg_o, port1_cfg_o, port2_cfg_o} == '0, 1'b1,
        "defaults");
    chk((done_cyc - last_ack) inside {[1000:1005]}, 1'b1,
        "abandon delay");
    $display("test silent_eeprom done");
    // No EEPROM fitted: defaults at once, no reads
    run_case(1'b0, 10'h000, 4'hF, w_a);
    chk(seen.size(), 0, "reads without EEPROM");
    chk({load_fail_o, cfg_access_en_o}, 2'b01, "absent status");
    chk({port0_cfg_o, port1_cfg_o, port2_cfg_o} == '0, 1'b1,
        "absent images");
    $display("test no_eeprom done");
    report_and_stop();
  end
endmodule
`default_nettype wire
